// ---- common/rsc_pkg.sv ----
// constants, types and rule summary for the reset source controller
// assumes a single 100 MHz clock domain and the documented register port
// What this block does
// R01 - five sources: pin, watchdog, supply, illegal opcode, data retention
// R02 - after any reset, fetch starts from vector at 0000H/0001H
// R03 - executing opcode FFH raises an internal reset
// R04 - illegal-opcode reset suppressed while a debug emulator is attached
// R05 - data reset only when supply falls below retention level
// R06 - outside party holds reset pin low at least 10 us
// R07 - option byte 000C1H select bit set to 1 for pin reset
// R08 - both on-chip oscillators stop while reset input is asserted
// R09 - special port pin hi-z in pin/retention reset, else pulled high
// R10 - shared pin reads low in pin reset, else pulled high while selected as reset input
// R11 - all other port pins hi-z during and after reset
// R12 - leave pin reset on rising pin, process, run on high-speed oscillator
// R13 - first power-up adds up to 3.39 ms supply-monitor delay
// R14 - watchdog and illegal-opcode resets release themselves
// R15 - reset stops CPU clock and peripherals; supply monitor keeps running
// R16 - reset acceptance loads status word with 06H
// R17 - during reset or stabilisation only program counter is undefined
// R18 - read-only 8-bit cause register at FFFA8H, unused bits zero
// R19 - byte read of cause register clears all three flags
// R20 - pin reset or retention reset clears all three flags
// R21 - each internal source sets its own flag, others held; two at once set only the first of supply, watchdog, trap
// R22 - software reads the cause register only with byte reads
// R23 - supply-monitor flag sits in bit 0
// R24 - select bit 0: general port; 1: reset input with pull-up
// R25 - pin synchronised; reset asserts at once, releases on the clock; here assertion also waits for the two-flop synchroniser and the clock
package rsc_pkg;
    localparam logic [19:0] RSC_CAUSE_ADDR    = 20'hfffa8;
    localparam logic [19:0] RSC_VECTOR_LO     = 20'h00000;
    localparam logic [19:0] RSC_VECTOR_HI     = 20'h00001;
    localparam logic [7:0]  RSC_OPC_ILLEGAL   = 8'hff;
    localparam logic [7:0]  RSC_PSW_RESET     = 8'h06;
    localparam logic [7:0]  RSC_CAUSE_RESET   = 8'h00;
    localparam int          RSC_BIT_SUPPLY    = 0;
    localparam int          RSC_BIT_WDOG      = 4;
    localparam int          RSC_BIT_TRAP      = 7;
    localparam int          RSC_CLK_MHZ       = 100;
    localparam int          RSC_MON_DELAY_US  = 3390;
    // longest time, exact cycle count
    localparam int          RSC_MON_CYCLES    = RSC_MON_DELAY_US * RSC_CLK_MHZ;
    localparam int          RSC_PROC_CYCLES   = 64;
    localparam int          RSC_CNT_W         = 24;

    typedef enum logic [2:0] {
        RSC_SRC_NONE,
        RSC_SRC_PIN,
        RSC_SRC_WDOG,
        RSC_SRC_SUPPLY,
        RSC_SRC_TRAP,
        RSC_SRC_RETAIN
    } rsc_src_t;
endpackage : rsc_pkg

// ---- common/rsc_src_if.sv ----
// bundle of synchronised reset requests between the main module and the
// request combiner; all signals on clk_in
`timescale 1ns/1ps
`default_nettype none
interface rsc_src_if;
    logic     pin_req;
    logic     wdog_req;
    logic     supply_req;
    logic     trap_req;
    logic     retain_req;
    logic     any_req;
    rsc_pkg::rsc_src_t src;
    modport producer (output pin_req, wdog_req, supply_req, trap_req,
                      retain_req, input any_req, src);
    modport combiner (input pin_req, wdog_req, supply_req, trap_req,
                      retain_req, output any_req, src);
endinterface : rsc_src_if
`default_nettype wire

// ---- hdl/rsc_combine.sv ----
// priority combiner of the five reset requests
// assumes all requests are already synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module rsc_combine
    import rsc_pkg::*;
(
    rsc_src_if.combiner req
);
    // pin and retention loss outrank the rest since they clear all flags
    assign req.any_req = req.pin_req | req.wdog_req | req.supply_req
                       | req.trap_req | req.retain_req; // R01
    assign req.src = req.retain_req ? RSC_SRC_RETAIN :
                     req.pin_req    ? RSC_SRC_PIN    :
                     req.supply_req ? RSC_SRC_SUPPLY :
                     req.wdog_req   ? RSC_SRC_WDOG   :
                     req.trap_req   ? RSC_SRC_TRAP   : RSC_SRC_NONE;
endmodule : rsc_combine
`default_nettype wire

// ---- hdl/rsc_reset_source_controller.sv ----
// reset source controller: combines requests, sequences release, drives
// oscillator/clock stops, pin states and the read-to-clear cause register
// assumes cpu fetch, opcode and register read strobes are on clk_in
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_controller
    import rsc_pkg::*;
#(
    parameter int MON_CYCLES  = RSC_MON_CYCLES,
    parameter int PROC_CYCLES = RSC_PROC_CYCLES
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    // pins and analog indications (asynchronous)
    input  wire logic        shared_reset_pin_in,
    input  wire logic        supply_low_in,
    input  wire logic        retain_low_in,
    input  wire logic        debug_attached_in,
    // option byte
    input  wire logic        reset_pin_select_in,
    // on-chip requesters (synchronous)
    input  wire logic        watchdog_overflow_in,
    input  wire logic        opcode_exec_in,
    input  wire logic [7:0]  opcode_in,
    // register read port
    input  wire logic        rd_en_in,
    input  wire logic        rd_byte_in,
    input  wire logic [19:0] rd_addr_in,
    output logic [7:0]       rd_data_out,
    // reset and clock control
    output logic             int_reset_out,
    output logic             hoco_run_out,
    output logic             loco_run_out,
    output logic             cpu_clk_en_out,
    output logic             periph_run_out,
    output logic             monitor_run_out,
    output logic             fetch_vector_out,
    output logic [19:0]      vector_addr_out,
    output logic             psw_load_out,
    output logic [7:0]       psw_value_out,
    output logic             pc_undefined_out,
    // pin control
    output logic             special_pin_pullup_out,
    output logic             special_pin_hiz_out,
    output logic             shared_pin_pullup_out,
    output logic             ports_hiz_out
);
    typedef enum logic [2:0] {
        RSC_ST_POWERUP,
        RSC_ST_RESET,
        RSC_ST_MON_WAIT,
        RSC_ST_PROC,
        RSC_ST_VEC_LO,
        RSC_ST_VEC_HI,
        RSC_ST_RUN
    } rsc_state_t;

    rsc_src_if src_bus ();

    rsc_combine u_combine (
        .req (src_bus.combiner)
    );

    // two-flop synchronisers for asynchronous inputs
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] async_raw;
    assign async_raw = {~shared_reset_pin_in, supply_low_in,
                        retain_low_in, debug_attached_in};
    always_ff @(posedge clk_in) begin
        sync1_ff <= async_raw; // R25
        sync2_ff <= sync1_ff;
    end

    wire pin_low   = sync2_ff[3];
    wire supply_lo = sync2_ff[2];
    wire retain_lo = sync2_ff[1];
    wire debug_on  = sync2_ff[0];

    // pin acts as reset only when selected; else it is a plain port
    assign src_bus.pin_req    = pin_low & reset_pin_select_in; // R24
    assign src_bus.wdog_req   = watchdog_overflow_in;
    assign src_bus.supply_req = supply_lo;
    assign src_bus.retain_req = retain_lo; // R05
    assign src_bus.trap_req   = opcode_exec_in & ~debug_on
                              & (opcode_in == RSC_OPC_ILLEGAL); // R03 R04

    // state and counters
    rsc_state_t           state_ff;
    rsc_state_t           nxt_state;
    logic [RSC_CNT_W-1:0] cnt_ff;
    logic [RSC_CNT_W-1:0] nxt_cnt;
    logic                 first_pwr_ff;
    rsc_src_t             last_src_ff;
    logic [7:0]           cause_ff;
    logic [7:0]           nxt_cause;

    wire cnt_done_mon  = (cnt_ff >= RSC_CNT_W'(MON_CYCLES - 1));
    wire cnt_done_proc = (cnt_ff >= RSC_CNT_W'(PROC_CYCLES - 1));
    wire in_reset      = (state_ff == RSC_ST_RESET)
                       | (state_ff == RSC_ST_POWERUP);
    wire releasing     = (state_ff == RSC_ST_MON_WAIT)
                       | (state_ff == RSC_ST_PROC);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff + 1'b1;
        if (src_bus.any_req) begin
            // requests take the reset state at once from any state
            nxt_state = RSC_ST_RESET; // R25
            nxt_cnt   = '0;
        end else begin
            unique case (state_ff)
                RSC_ST_POWERUP,
                RSC_ST_RESET: begin
                    // pin high again or self-releasing source gone
                    nxt_cnt   = '0;
                    nxt_state = first_pwr_ff ? RSC_ST_MON_WAIT
                                             : RSC_ST_PROC; // R12 R14
                end
                RSC_ST_MON_WAIT: begin
                    if (cnt_done_mon) begin
                        nxt_state = RSC_ST_PROC; // R13
                        nxt_cnt   = '0;
                    end
                end
                RSC_ST_PROC: begin
                    if (cnt_done_proc) begin
                        nxt_state = RSC_ST_VEC_LO;
                    end
                end
                RSC_ST_VEC_LO: nxt_state = RSC_ST_VEC_HI; // R02
                RSC_ST_VEC_HI: nxt_state = RSC_ST_RUN;
                RSC_ST_RUN:    nxt_cnt   = cnt_ff;
            endcase
        end
    end

    // cause flags: hardware set wins over the read clear
    wire cause_rd = rd_en_in & rd_byte_in
                  & (rd_addr_in == RSC_CAUSE_ADDR); // R19 R22
    always_comb begin
        nxt_cause = cause_ff;
        if (cause_rd) begin
            nxt_cause = RSC_CAUSE_RESET; // R19
        end
        unique case (src_bus.src)
            RSC_SRC_PIN,
            RSC_SRC_RETAIN: nxt_cause = RSC_CAUSE_RESET; // R20
            RSC_SRC_TRAP:   nxt_cause[RSC_BIT_TRAP]   = 1'b1; // R21
            RSC_SRC_WDOG:   nxt_cause[RSC_BIT_WDOG]   = 1'b1; // R21
            RSC_SRC_SUPPLY: nxt_cause[RSC_BIT_SUPPLY] = 1'b1; // R21 R23
            RSC_SRC_NONE:   ;
        endcase
        // unused bits always zero
        nxt_cause = nxt_cause & ((8'h01 << RSC_BIT_TRAP)
                  | (8'h01 << RSC_BIT_WDOG) | (8'h01 << RSC_BIT_SUPPLY)); // R18
    end

    // cause register is not wiped by srst_in; only sources and byte reads of it touch it
    always_ff @(posedge clk_in) begin
        cause_ff <= nxt_cause;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_ff     <= RSC_ST_POWERUP;
            cnt_ff       <= '0;
            first_pwr_ff <= 1'b1;
            last_src_ff  <= RSC_SRC_NONE;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            if (state_ff == RSC_ST_MON_WAIT && cnt_done_mon) begin
                first_pwr_ff <= 1'b0;
            end
            if (src_bus.any_req) begin
                last_src_ff <= src_bus.src;
            end else if (state_ff == RSC_ST_RUN) begin
                last_src_ff <= RSC_SRC_NONE;
            end
        end
    end

    // pin-state decode for the current reset cause
    wire pin_or_retain = in_reset & ((last_src_ff == RSC_SRC_PIN)
                       | (last_src_ff == RSC_SRC_RETAIN));
    wire pin_reset_now = in_reset & (last_src_ff == RSC_SRC_PIN);
    wire vec_lo        = (state_ff == RSC_ST_VEC_LO);
    wire vec_hi        = (state_ff == RSC_ST_VEC_HI);

    // registered outputs
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_data_out            <= 8'h00;
            int_reset_out          <= 1'b1;
            hoco_run_out           <= 1'b0;
            loco_run_out           <= 1'b0;
            cpu_clk_en_out         <= 1'b0;
            periph_run_out         <= 1'b0;
            monitor_run_out        <= 1'b1;
            fetch_vector_out       <= 1'b0;
            vector_addr_out        <= RSC_VECTOR_LO;
            psw_load_out           <= 1'b0;
            psw_value_out          <= RSC_PSW_RESET;
            pc_undefined_out       <= 1'b1;
            special_pin_pullup_out <= 1'b0;
            special_pin_hiz_out    <= 1'b1;
            shared_pin_pullup_out  <= 1'b0;
            ports_hiz_out          <= 1'b1;
        end else begin
            rd_data_out <= cause_rd ? cause_ff : 8'h00; // R18
            int_reset_out <= src_bus.any_req | in_reset | releasing
                           | vec_lo | vec_hi; // R01
            // oscillators stop during any reset; hoco restarts to release
            hoco_run_out <= ~(src_bus.any_req | in_reset); // R08 R12
            loco_run_out <= ~(src_bus.any_req | in_reset); // R08
            cpu_clk_en_out <= (state_ff == RSC_ST_RUN)
                            & ~src_bus.any_req; // R15
            periph_run_out <= (state_ff == RSC_ST_RUN)
                            & ~src_bus.any_req; // R15
            monitor_run_out <= 1'b1; // R15
            fetch_vector_out <= vec_lo | vec_hi; // R02
            vector_addr_out  <= vec_hi ? RSC_VECTOR_HI : RSC_VECTOR_LO;
            psw_load_out     <= vec_lo; // R16
            psw_value_out    <= RSC_PSW_RESET; // R16
            pc_undefined_out <= src_bus.any_req | in_reset | releasing; // R17
            special_pin_hiz_out    <= pin_or_retain; // R09
            special_pin_pullup_out <= ~pin_or_retain; // R09
            // pull-up only when pin is reset input and not driven low
            shared_pin_pullup_out  <= reset_pin_select_in
                                    & ~pin_reset_now; // R10 R24
            ports_hiz_out          <= 1'b1; // R11
        end
    end
endmodule : rsc_reset_source_controller
`default_nettype wire

// ---- sim/rsc_asserts.sv ----
// concurrent checks on the reset source controller's top-level ports
// bound to every controller instance; one clock domain
`timescale 1ns/1ps
`default_nettype none
module rsc_asserts (
    // clock and reset
    input wire logic        clk_in,
    input wire logic        srst_in,
    // watched ports
    input wire logic        watchdog_overflow_in,
    input wire logic [7:0]  rd_data_out,
    input wire logic        int_reset_out,
    input wire logic        hoco_run_out,
    input wire logic        loco_run_out,
    input wire logic        cpu_clk_en_out,
    input wire logic        periph_run_out,
    input wire logic        monitor_run_out,
    input wire logic        fetch_vector_out,
    input wire logic [19:0] vector_addr_out,
    input wire logic        psw_load_out,
    input wire logic [7:0]  psw_value_out,
    input wire logic        pc_undefined_out,
    input wire logic        special_pin_hiz_out,
    input wire logic        special_pin_pullup_out,
    input wire logic        ports_hiz_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    osc_stop_a: assert property ($rose(int_reset_out) |->
        !hoco_run_out && !loco_run_out) else $error("osc running in reset");
    cpu_stop_a: assert property (int_reset_out |->
        !cpu_clk_en_out && !periph_run_out)
        else $error("cpu clock on in reset");
    // the vector fetch itself loads the pc, so it is defined there
    pc_undef_a: assert property (int_reset_out && !fetch_vector_out |->
        pc_undefined_out) else $error("pc not flagged undefined");
    wdog_take_a: assert property (watchdog_overflow_in |=> int_reset_out)
        else $error("watchdog request ignored");
    vector_seq_a: assert property ($rose(fetch_vector_out) |->
        vector_addr_out == 20'h00000 ##1 (fetch_vector_out &&
        vector_addr_out == 20'h00001) ##1 !fetch_vector_out)
        else $error("bad vector fetch");
    psw_value_a: assert property (psw_load_out |->
        psw_value_out == 8'h06 && !cpu_clk_en_out) else $error("bad psw");
    pin_pair_a: assert property (special_pin_hiz_out !=
        special_pin_pullup_out) else $error("special pin state clash");
    unused_zero_a: assert property ((rd_data_out & 8'h6e) == 8'h00)
        else $error("unused cause bit set");
    always_on_a: assert property (monitor_run_out && ports_hiz_out)
        else $error("monitor off or ports driven");
    run_start_a: assert property ($rose(cpu_clk_en_out) |->
        hoco_run_out && special_pin_pullup_out) else $error("bad run start");
endmodule : rsc_asserts
bind rsc_reset_source_controller rsc_asserts u_rsc_asserts (
    .clk_in(clk_in), .srst_in(srst_in),
    .watchdog_overflow_in(watchdog_overflow_in), .rd_data_out(rd_data_out),
    .int_reset_out(int_reset_out), .hoco_run_out(hoco_run_out),
    .loco_run_out(loco_run_out), .cpu_clk_en_out(cpu_clk_en_out),
    .periph_run_out(periph_run_out),
    .monitor_run_out(monitor_run_out), .fetch_vector_out(fetch_vector_out),
    .vector_addr_out(vector_addr_out), .psw_load_out(psw_load_out),
    .psw_value_out(psw_value_out), .pc_undefined_out(pc_undefined_out),
    .special_pin_hiz_out(special_pin_hiz_out),
    .special_pin_pullup_out(special_pin_pullup_out),
    .ports_hiz_out(ports_hiz_out));
`default_nettype wire

// ---- sim/rsc_pin_partner.sv ----
// board-side driver of the shared reset pin
// pin sits on its pull-up whenever the driver lets go
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_partner #(
    parameter int LOW_CYCLES = 1000
) (
    // clock and request
    input  wire logic clk_in,
    input  wire logic go_in,
    // pin
    output logic      pin_out
);
    int cnt_ff = 0;
    always @(posedge clk_in) begin
        if (go_in) cnt_ff <= LOW_CYCLES;
        else if (cnt_ff > 0) cnt_ff <= cnt_ff - 1;
    end
    assign pin_out = (cnt_ff == 0);
endmodule : rsc_pin_partner
`default_nettype wire

// ---- sim/rsc_reset_source_controller_tb.sv ----
// self-checking bench for the reset source controller
// short release counts; the pin partner holds its low for 10 us
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_controller_tb;
    import rsc_pkg::*;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        go = 1'b0, supply_low = 1'b0, retain_low = 1'b0;
    logic        debug_on = 1'b0, pin_sel = 1'b1, wdog = 1'b0;
    logic        op_exec = 1'b0, rd_en = 1'b0, rd_byte = 1'b0;
    logic [7:0]  opcode = 8'h00;
    logic [19:0] rd_addr = 20'h00000;
    logic [7:0]  rd_data, d;
    logic        pin, int_rst, hoco, loco, run, sp_hiz, sp_pu, sh_pu;
    int          bad_count = 0, checks = 0, cyc = 0;
    always #5 clk_in = ~clk_in;
    rsc_pin_partner u_rsc_pin_partner (.clk_in(clk_in), .go_in(go),
        .pin_out(pin));
    rsc_reset_source_controller #(.MON_CYCLES(20), .PROC_CYCLES(4))
    u_rsc_reset_source_controller (
        .clk_in(clk_in), .srst_in(srst_in), .shared_reset_pin_in(pin),
        .supply_low_in(supply_low), .retain_low_in(retain_low),
        .debug_attached_in(debug_on), .reset_pin_select_in(pin_sel),
        .watchdog_overflow_in(wdog), .opcode_exec_in(op_exec),
        .opcode_in(opcode), .rd_en_in(rd_en), .rd_byte_in(rd_byte),
        .rd_addr_in(rd_addr), .rd_data_out(rd_data),
        .int_reset_out(int_rst), .hoco_run_out(hoco), .loco_run_out(loco),
        .cpu_clk_en_out(run), .periph_run_out(), .monitor_run_out(),
        .fetch_vector_out(), .vector_addr_out(), .psw_load_out(),
        .psw_value_out(), .pc_undefined_out(),
        .special_pin_pullup_out(sp_pu), .special_pin_hiz_out(sp_hiz),
        .shared_pin_pullup_out(sh_pu), .ports_hiz_out());
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    task automatic rd(input logic [19:0] a, input logic b);
        @(posedge clk_in);
        rd_en <= 1'b1;
        rd_addr <= a;
        rd_byte <= b;
        @(posedge clk_in);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask : rd
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    task automatic wait_run();
        int i;
        i = 0;
        while (run !== 1'b1 && i < 2000) begin
            tick(1);
            i++;
        end
        chk({7'h0, run}, 8'h01);
    endtask : wait_run
    // one-cycle request on a synchronous input, then wait two cycles for reset to be taken
    task automatic sync_pulse(input logic is_wdog, input logic [7:0] op);
        @(posedge clk_in);
        wdog <= is_wdog;
        op_exec <= !is_wdog;
        opcode <= op;
        @(posedge clk_in);
        wdog <= 1'b0;
        op_exec <= 1'b0;
        tick(2);
    endtask : sync_pulse
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (8) @(posedge clk_in);
        srst_in <= 1'b0;
        wait_run();
        chk({7'h0, hoco}, 8'h01);
        @(posedge clk_in) go <= 1'b1;
        @(posedge clk_in) go <= 1'b0;
        tick(10);
        chk({3'h0, int_rst, hoco, loco, sh_pu, sp_hiz}, 8'h11);
        wait_run();
        rd(RSC_CAUSE_ADDR, 1'b1);
        chk(d, 8'h00);
        sync_pulse(1'b0, 8'hff);
        chk({6'h0, int_rst, sh_pu}, 8'h03);
        wait_run();
        sync_pulse(1'b1, 8'h00);
        chk({6'h0, int_rst, sp_pu}, 8'h03);
        wait_run();
        rd(RSC_CAUSE_ADDR, 1'b1);
        chk(d, 8'h90);
        @(posedge clk_in) supply_low <= 1'b1;
        tick(6);
        chk({7'h0, int_rst}, 8'h01);
        @(posedge clk_in) supply_low <= 1'b0;
        wait_run();
        rd(RSC_CAUSE_ADDR, 1'b0);
        chk(d, 8'h00);
        rd(20'hfffa9, 1'b1);
        chk(d, 8'h00);
        rd(RSC_CAUSE_ADDR, 1'b1);
        chk(d, 8'h01);
        sync_pulse(1'b1, 8'h00);
        wait_run();
        @(posedge clk_in) retain_low <= 1'b1;
        tick(6);
        chk({6'h0, int_rst, sp_hiz}, 8'h03);
        @(posedge clk_in) retain_low <= 1'b0;
        wait_run();
        rd(RSC_CAUSE_ADDR, 1'b1);
        chk(d, 8'h00);
        @(posedge clk_in) debug_on <= 1'b1;
        tick(4);
        sync_pulse(1'b0, 8'hff);
        chk({7'h0, int_rst}, 8'h00);
        @(posedge clk_in) debug_on <= 1'b0;
        tick(4);
        sync_pulse(1'b0, 8'hfe);
        chk({7'h0, int_rst}, 8'h00);
        @(posedge clk_in) pin_sel <= 1'b0;
        @(posedge clk_in) go <= 1'b1;
        @(posedge clk_in) go <= 1'b0;
        tick(10);
        chk({6'h0, int_rst, sh_pu}, 8'h00);
        tick(1000);
        tally_and_finish();
    end
endmodule : rsc_reset_source_controller_tb
`default_nettype wire
